// ### adc_conversion_control.sv
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Resolution bit picks 10-bit or 8-bit result
// - Sample-hold conversion takes 28 or 33 cycles
// - Software trigger starts on conversion_start write
// - External pin falling edge triggers conversion
// - Motor timer B2 request triggers conversion
// - Hardware trigger needs conversion_start already set
// - Retrigger during conversion aborts and restarts, except in repeat sweep 1
// - DMA mode stores every result in register 0
// - DMA request after each pin conversion
// - Extended pins usable only one-shot and repeat
// - Extended pin results go to registers 0/1
// - Extended select decodes four pin uses
// - Op-amp mode routes channel, stores per channel
// - Ladder disconnected while ladder_connect is low
// - Repeat sweep 1 ignores triggers mid-conversion
// - DMA mode interrupt after every conversion
// - One-shot software trigger clears start when done
module adc_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter logic [7:0] CONV_NOSH8  = 8'h2f,
  parameter logic [7:0] CONV_NOSH10 = 8'h3b
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_trigger_pin,
  input  wire logic        motor_timer_b2_irq,
  input  wire logic [9:0]  adc_sample,
  output logic      [2:0]  channel_sel,
  output logic             convert_ext0,
  output logic             convert_ext1,
  output logic             opamp_route_en,
  output logic             ladder_connect_out,
  output logic             sample_hold_on,
  output logic             converting,
  output logic             dma_request,
  output logic             conv_irq
);

  // Bus slave state
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic        hreadyout_reg;
  // Software-visible control
  logic [7:0]  ctrl0_reg, ctrl0_next;
  logic [6:0]  ctrl1_reg, ctrl1_next;
  logic [1:0]  ctrl2_reg, ctrl2_next;
  logic        ctrl3_reg, ctrl3_next;
  // Conversion engine
  state_type   state_reg, state_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [2:0]  ch_reg, ch_next;
  logic [9:0]  result_mem [8];
  logic [9:0]  result_next [8];
  logic        dma_reg, dma_next, irq_reg, irq_next;
  logic [5:0]  out_reg, out_next;
  // Trigger pin synchroniser
  logic        sync1_reg, sync2_reg, sync3_reg;

  logic        addr_ok, wr_ctrl0, wr_ctrl1, wr_ctrl2, wr_ctrl3;
  logic        ext_fall, trig_evt, done, last_ch, trig_mode;
  logic [7:0]  conv_limit;
  logic [2:0]  first_ch, last_idx, tgt_idx;
  logic [1:0]  ext_eff;
  logic [9:0]  res_word;
  mode_type    mode;

  assign mode      = mode_type'(ctrl0_reg[MODE_LSB +: 3]);
  assign trig_mode = ctrl0_reg[TRG_BIT];
  assign addr_ok   = hsel && hready && htrans[1] && (hsize == SIZE_WORD[2:0]);
  assign wr_ctrl0  = wr_pend_reg && (waddr_reg == ADC_CONTROL_0_OFS);
  assign wr_ctrl1  = wr_pend_reg && (waddr_reg == ADC_CONTROL_1_OFS);
  assign wr_ctrl2  = wr_pend_reg && (waddr_reg == ADC_CONTROL_2_OFS);
  assign wr_ctrl3  = wr_pend_reg && (waddr_reg == ADC_CONTROL_3_OFS);

  // Trigger selection
  assign ext_fall = sync3_reg && !sync2_reg;
  assign trig_evt = trig_mode && (ctrl2_reg[HWTRG_BIT] ? motor_timer_b2_irq
                                                       : ext_fall);

  // Conversion length and result shaping
  assign conv_limit = ctrl2_reg[SH_BIT]
                    ? (ctrl1_reg[RES_BIT] ? CONV_SH10 : CONV_SH8)
                    : (ctrl1_reg[RES_BIT] ? CONV_NOSH10 : CONV_NOSH8);
  assign res_word = ctrl1_reg[RES_BIT] ? adc_sample
                                       : {2'b00, adc_sample[9:2]};

  // Extended pins only in one-shot and repeat
  assign ext_eff = (mode == MODE_ONESHOT || mode == MODE_REPEAT)
                 ? ctrl1_reg[EXT_LSB +: 2] : EXT_NONE;
  assign tgt_idx = ctrl3_reg ? 3'h0
                 : (ext_eff == EXT_PIN0) ? 3'h0
                 : (ext_eff == EXT_PIN1) ? 3'h1
                 : ch_reg;

  // Sweep bounds
  assign first_ch = (mode == MODE_ONESHOT || mode == MODE_REPEAT) ? ctrl0_reg[CH_LSB +: 3]
                                                                  : 3'h0;
  assign last_idx = (mode == MODE_RSWEEP1) ? 3'h7 : {ctrl1_reg[SCAN_LSB +: 2], 1'b1};
  assign last_ch  = (ch_reg == last_idx);
  assign done     = (state_reg == ST_CONV) && ctrl0_reg[START_BIT]
                 && !(trig_evt && mode != MODE_RSWEEP1)
                 && (cnt_reg == conv_limit - 8'h01);

  // Bus slave next state
  always_comb begin
    wr_pend_next = addr_ok && hwrite;
    waddr_next   = addr_ok ? haddr[7:0] : waddr_reg;
    hrdata_next  = 32'h0;
    if (addr_ok && !hwrite) begin
      if (haddr[7:0] == ADC_CONTROL_0_OFS) begin
        hrdata_next = {24'h0, ctrl0_reg};
      end else if (haddr[7:0] == ADC_CONTROL_1_OFS) begin
        hrdata_next = {25'h0, ctrl1_reg};
      end else if (haddr[7:0] == ADC_CONTROL_2_OFS) begin
        hrdata_next = {30'h0, ctrl2_reg};
      end else if (haddr[7:0] == ADC_CONTROL_3_OFS) begin
        hrdata_next = {31'h0, ctrl3_reg};
      end else if (haddr[7:0] == STATUS_OFS) begin
        hrdata_next = {28'h0, ch_reg, state_reg == ST_CONV};
      end else if (haddr[7:5] == RESULT_BASE_SEL && haddr[1:0] == 2'b00) begin
        hrdata_next = {22'h0, result_mem[haddr[4:2]]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg   <= 1'b0;
      waddr_reg     <= 8'h00;
      hrdata_reg    <= 32'h0;
      hreadyout_reg <= 1'b0;
    end else begin
      wr_pend_reg   <= wr_pend_next;
      waddr_reg     <= waddr_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= 1'b1;
    end
  end

  // Control registers and conversion engine next state
  always_comb begin
    ctrl0_next  = ctrl0_reg;
    ctrl1_next  = wr_ctrl1 ? hwdata[6:0] : ctrl1_reg;
    ctrl2_next  = wr_ctrl2 ? hwdata[1:0] : ctrl2_reg;
    ctrl3_next  = wr_ctrl3 ? hwdata[DMA_BIT] : ctrl3_reg;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    ch_next     = ch_reg;
    result_next = result_mem;
    dma_next    = 1'b0;
    irq_next    = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (ctrl0_reg[START_BIT]) begin
          ch_next  = first_ch;
          cnt_next = 8'h00;
          state_next = trig_mode ? ST_WAIT : ST_CONV;
        end
      end
      ST_WAIT: begin
        if (!ctrl0_reg[START_BIT]) begin
          state_next = ST_IDLE;
        end else if (trig_evt) begin
          state_next = ST_CONV;
          cnt_next   = 8'h00;
        end
      end
      ST_CONV: begin
        if (!ctrl0_reg[START_BIT]) begin
          state_next = ST_IDLE;
        end else if (trig_evt && mode != MODE_RSWEEP1) begin
          cnt_next = 8'h00;
        end else if (done) begin
          result_next[tgt_idx] = res_word;
          dma_next = ctrl3_reg;
          cnt_next = 8'h00;
          case (mode)
            MODE_ONESHOT: irq_next = 1'b1;
            MODE_SWEEP:   irq_next = ctrl3_reg || last_ch;
            default:      irq_next = ctrl3_reg;
          endcase
          if (mode == MODE_ONESHOT || (mode == MODE_SWEEP && last_ch)) begin
            ch_next = first_ch;
            if (trig_mode) begin
              state_next = ST_WAIT;
            end else begin
              state_next = ST_IDLE;
              ctrl0_next[START_BIT] = 1'b0;
            end
          end else if (mode != MODE_REPEAT) begin
            ch_next = last_ch ? 3'h0 : ch_reg + 3'h1;
          end
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (wr_ctrl0) begin
      ctrl0_next = hwdata[7:0];
    end
    out_next = {ext_eff == EXT_PIN0, ext_eff[1], ext_eff == EXT_OPAMP,
                ctrl1_reg[LADDER_BIT], ctrl2_reg[SH_BIT],
                state_next == ST_CONV};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_reg  <= CTRL0_RST;
      ctrl1_reg  <= CTRL1_RST;
      ctrl2_reg  <= CTRL2_RST;
      ctrl3_reg  <= 1'b0;
      state_reg  <= ST_IDLE;
      cnt_reg    <= 8'h00;
      ch_reg     <= 3'h0;
      result_mem <= '{default: 10'h000};
      dma_reg    <= 1'b0;
      irq_reg    <= 1'b0;
      out_reg    <= 6'h00;
    end else begin
      ctrl0_reg  <= ctrl0_next;
      ctrl1_reg  <= ctrl1_next;
      ctrl2_reg  <= ctrl2_next;
      ctrl3_reg  <= ctrl3_next;
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      ch_reg     <= ch_next;
      result_mem <= result_next;
      dma_reg    <= dma_next;
      irq_reg    <= irq_next;
      out_reg    <= out_next;
    end
  end

  // Trigger pin synchroniser and edge stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
    end else begin
      sync1_reg <= ext_trigger_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign hrdata             = hrdata_reg;
  assign hreadyout          = hreadyout_reg;
  assign hresp              = 1'b0;
  assign channel_sel        = ch_reg;
  assign convert_ext0       = out_reg[5];
  assign convert_ext1       = out_reg[4];
  assign opamp_route_en     = out_reg[3];
  assign ladder_connect_out = out_reg[2];
  assign sample_hold_on     = out_reg[1];
  assign converting         = out_reg[0];
  assign dma_request        = dma_reg;
  assign conv_irq           = irq_reg;

  // Checks
  logic fresh;
  assign fresh = (state_reg == ST_CONV) && (cnt_reg == 8'h00);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_sw_start;
    state_reg == ST_IDLE && ctrl0_reg[START_BIT] && !trig_mode;
  endsequence
  sequence s_retrigger;
    state_reg == ST_CONV && ctrl0_reg[START_BIT] && trig_evt && mode != MODE_RSWEEP1;
  endsequence

  property p_res8;
    done && !ctrl1_reg[RES_BIT] |=> result_mem[$past(tgt_idx)][9:8] == 2'b00;
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result has upper bits");
  property p_sh8;
    done && ctrl2_reg[SH_BIT] && !ctrl1_reg[RES_BIT] && $stable(ctrl2_reg)
      |-> $past(fresh, 27);
  endproperty
  a_sh8: assert property (p_sh8) else $error("8-bit hold conversion length wrong");
  property p_sh10;
    done && ctrl2_reg[SH_BIT] && ctrl1_reg[RES_BIT] && $stable(ctrl2_reg)
      |-> $past(fresh, 32);
  endproperty
  a_sh10: assert property (p_sh10) else $error("10-bit hold conversion length wrong");
  property p_sw_start;
    s_sw_start |=> state_reg == ST_CONV && cnt_reg == 8'h00;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start missed");
  property p_wait_hold;
    state_reg == ST_WAIT && !trig_evt && ctrl0_reg[START_BIT] && !wr_pend_reg
      |=> state_reg == ST_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("started without trigger");
  property p_restart;
    s_retrigger |=> cnt_reg == 8'h00 && !dma_request ##1 cnt_reg == 8'h01 || !converting;
  endproperty
  a_restart: assert property (p_restart) else $error("retrigger did not restart");
  property p_dma_tgt;
    done && ctrl3_reg |-> tgt_idx == 3'h0 ##1 dma_request && result_mem[0] == $past(res_word);
  endproperty
  a_dma_tgt: assert property (p_dma_tgt) else $error("DMA result or request wrong");
  property p_ignore;
    state_reg == ST_CONV && mode == MODE_RSWEEP1 && trig_evt && !done && ctrl0_reg[START_BIT]
      && !wr_pend_reg |=> cnt_reg == $past(cnt_reg) + 8'h01;
  endproperty
  a_ignore: assert property (p_ignore) else $error("sweep 1 restarted on trigger");
  property p_oneshot_clear;
    done && mode == MODE_ONESHOT && !trig_mode && !wr_pend_reg
      |=> !ctrl0_reg[START_BIT] && conv_irq && state_reg == ST_IDLE;
  endproperty
  a_oneshot_clear: assert property (p_oneshot_clear) else $error("start not cleared");

endmodule
`default_nettype wire

// ### adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] ADC_CONTROL_0_OFS = 8'h00;
  localparam logic [7:0] ADC_CONTROL_1_OFS = 8'h04;
  localparam logic [7:0] ADC_CONTROL_2_OFS = 8'h08;
  localparam logic [7:0] ADC_CONTROL_3_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS        = 8'h10;
  localparam logic [2:0] RESULT_BASE_SEL   = 3'h1;
  // adc_control_0 fields
  localparam int CH_LSB     = 0;
  localparam int MODE_LSB   = 3;
  localparam int TRG_BIT    = 6;
  localparam int START_BIT  = 7;
  // adc_control_1 fields
  localparam int SCAN_LSB   = 0;
  localparam int RES_BIT    = 3;
  localparam int EXT_LSB    = 4;
  localparam int LADDER_BIT = 6;
  // adc_control_2 and adc_control_3 fields
  localparam int SH_BIT     = 0;
  localparam int HWTRG_BIT  = 1;
  localparam int DMA_BIT    = 0;
  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [6:0] CTRL1_RST = 7'h00;
  localparam logic [1:0] CTRL2_RST = 2'h0;
  // Conversion lengths in converter clock cycles with sample and hold
  localparam logic [7:0] CONV_SH8  = 8'h1c;
  localparam logic [7:0] CONV_SH10 = 8'h21;
  localparam logic [31:0] SIZE_WORD = 32'h2;
  typedef enum logic [2:0] {
    MODE_ONESHOT = 3'b000,
    MODE_REPEAT  = 3'b001,
    MODE_SWEEP   = 3'b010,
    MODE_RSWEEP0 = 3'b011,
    MODE_RSWEEP1 = 3'b100
  } mode_type;
  typedef enum logic [1:0] {
    EXT_NONE  = 2'b00,
    EXT_PIN0  = 2'b01,
    EXT_PIN1  = 2'b10,
    EXT_OPAMP = 2'b11
  } ext_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } state_type;
endpackage
`default_nettype wire

// ### adc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module adc_far_side (
  input  wire logic       hclk,
  input  wire logic       dma_request,
  output logic            ext_trigger_pin,
  output logic      [9:0] adc_sample,
  output logic            motor_timer_b2_irq
);
  int dma_count;
  initial begin
    ext_trigger_pin = 1'b1;
    motor_timer_b2_irq = 1'b0;
    adc_sample = 10'h2d6;
    dma_count = 0;
  end
  // DMA side counts one transfer per request
  always @(posedge hclk) begin
    if (dma_request === 1'b1) begin
      dma_count <= dma_count + 1;
    end
  end
  // Trigger pin low for four cycles, then back high
  task automatic fall_edge();
    @(posedge hclk);
    ext_trigger_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    ext_trigger_pin <= 1'b1;
  endtask
  // Timer B2 count end pulse
  task automatic timer_done();
    @(posedge hclk);
    motor_timer_b2_irq <= 1'b1;
    @(posedge hclk);
    motor_timer_b2_irq <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_ctrl_pkg::*;
  localparam logic [7:0] NS8  = 8'h08;
  localparam logic [7:0] NS10 = 8'h0a;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_trigger_pin;
  logic        motor_timer_b2_irq, convert_ext0, convert_ext1, opamp_route_en;
  logic        ladder_connect_out, sample_hold_on, converting, dma_request, conv_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, channel_sel;
  logic [9:0]  adc_sample;
  int          n_mismatch, cmp_count, n, d0;
  logic [31:0] et [4] = '{32'(NS8), 32'(NS10), 32'd28, 32'd33};
  mode_type    md [2] = '{MODE_ONESHOT, MODE_RSWEEP1};
  logic [2:0]  ev [4] = '{3'h0, 3'h1, 3'h2, 3'h6};
  logic [7:0]  tg [4] = '{8'h00, 8'h20, 8'h24, 8'h38};
  adc_conversion_control #(.CONV_NOSH8(NS8), .CONV_NOSH10(NS10)) adc_conversion_control_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_trigger_pin(ext_trigger_pin), .motor_timer_b2_irq(motor_timer_b2_irq),
    .adc_sample(adc_sample), .channel_sel(channel_sel), .convert_ext0(convert_ext0),
    .convert_ext1(convert_ext1), .opamp_route_en(opamp_route_en),
    .ladder_connect_out(ladder_connect_out), .sample_hold_on(sample_hold_on),
    .converting(converting), .dma_request(dma_request), .conv_irq(conv_irq));
  adc_far_side far_i (
    .hclk(hclk), .dma_request(dma_request), .ext_trigger_pin(ext_trigger_pin),
    .adc_sample(adc_sample), .motor_timer_b2_irq(motor_timer_b2_irq));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus phase, ends at the edge where hready is high
  task automatic phase(output logic [31:0] v);
    logic r;
    do begin
      @(posedge hclk);
      r = hreadyout;
      v = hrdata;
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    phase(rd);
    htrans <= 2'b00;
    hwdata <= d;
    phase(rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk(hresp, 0);
  endtask
  // Cycles from converting seen high to conv_irq seen high
  task automatic conv_time(output int c);
    int k;
    c = 0;
    k = 0;
    while (converting !== 1'b1 && k < 300) begin
      @(posedge hclk);
      #1;
      k++;
    end
    while (conv_irq !== 1'b1 && c < 400) begin
      @(posedge hclk);
      #1;
      c++;
    end
  endtask
  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rchk(ADC_CONTROL_0_OFS, 32'h0);
    rchk(ADC_CONTROL_1_OFS, 32'h0);
    rchk(8'h40, 32'h0);
    wr(STATUS_OFS, 32'hffffffff);
    rchk(STATUS_OFS, 32'h0);
    wr(ADC_CONTROL_2_OFS, 32'hffffffff);
    rchk(ADC_CONTROL_2_OFS, 32'h3);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(ADC_CONTROL_1_OFS, 32'h40 | (32'(i[0]) << 3));
      wr(ADC_CONTROL_2_OFS, 32'(i[1]));
      fork
        wr(ADC_CONTROL_0_OFS, 32'h80 + 32'(i));
        conv_time(n);
      join
      chk(n, et[i]);
      chk(sample_hold_on, i[1]);
      chk(ladder_connect_out, 1);
      rchk(8'h20 + 8'(4 * i), i[0] ? 32'h2d6 : 32'hb5);
      rchk(ADC_CONTROL_0_OFS, 32'(i));
    end
    $display("test timing done");
    wr(ADC_CONTROL_1_OFS, 32'h48);
    wr(ADC_CONTROL_2_OFS, 32'h1);
    wr(ADC_CONTROL_3_OFS, 32'h1);
    for (int j = 0; j < 2; j++) begin
      wr(ADC_CONTROL_0_OFS, {24'h0, 1'b1, 1'b1, md[j], 3'b010});
      repeat (20) @(posedge hclk);
      #1;
      chk(converting, 0);
      d0 = far_i.dma_count;
      fork
        begin
          far_i.fall_edge();
          repeat (10) @(posedge hclk);
          far_i.fall_edge();
        end
        conv_time(n);
      join
      chk(n > 33, j == 0);
      chk(n < 33, 0);
      if (j == 0) begin
        repeat (2) @(posedge hclk);
        chk(far_i.dma_count - d0, 1);
        rchk(ADC_CONTROL_0_OFS, 32'hc2);
        rchk(8'h20, 32'h2d6);
        rchk(8'h28, 32'hb5);
      end
      wr(ADC_CONTROL_0_OFS, 32'h0);
    end
    wr(ADC_CONTROL_2_OFS, 32'h3);
    wr(ADC_CONTROL_0_OFS, 32'hc1);
    far_i.fall_edge();
    repeat (10) @(posedge hclk);
    #1;
    chk(converting, 0);
    fork
      far_i.timer_done();
      conv_time(n);
    join
    chk(n, et[3]);
    wr(ADC_CONTROL_0_OFS, 32'h0);
    $display("test triggers done");
    wr(ADC_CONTROL_3_OFS, 32'h0);
    wr(ADC_CONTROL_2_OFS, 32'h0);
    for (int e = 1; e < 4; e++) begin
      far_i.adc_sample <= 10'h100 + 10'(e);
      wr(ADC_CONTROL_1_OFS, 32'h48 | (32'(e) << 4));
      fork
        wr(ADC_CONTROL_0_OFS, 32'h86);
        conv_time(n);
      join
      chk({opamp_route_en, convert_ext1, convert_ext0}, ev[e]);
      chk(channel_sel, 6);
      rchk(tg[e], 32'h100 + 32'(e));
    end
    wr(ADC_CONTROL_1_OFS, 32'h58);
    wr(ADC_CONTROL_3_OFS, 32'h1);
    fork
      wr(ADC_CONTROL_0_OFS, 32'h90);
      conv_time(n);
    join
    chk(convert_ext0, 0);
    wr(ADC_CONTROL_0_OFS, 32'h0);
    wr(ADC_CONTROL_1_OFS, 32'h0);
    repeat (3) @(posedge hclk);
    #1;
    chk(ladder_connect_out, 0);
    $display("test extended pins done");
    complete_run();
  end
endmodule
`default_nettype wire
